//--- hdl/cio_pkg.sv
// constants, types and register map of the continuous i/o mode controller
// assumes a byte-wide serial link: received bytes arrive one cycle each
package cio_pkg;
	// link characters
	localparam logic [7:0] CH_DOLLAR = 8'h24;
	localparam logic [7:0] CH_HASH = 8'h23;
	localparam logic [7:0] CH_STAR = 8'h2A;
	localparam logic [7:0] CH_QUERY = 8'h3F;
	localparam logic [7:0] CH_CR = 8'h0D;
	localparam logic [7:0] CH_PLUS = 8'h2B;
	localparam logic [7:0] CH_DOT = 8'h2E;
	localparam logic [7:0] CH_ZERO = 8'h30;
	localparam logic [7:0] CH_HEX_OFS = 8'h37;
	// continuous kinds, answered as D, T, E, C or I
	typedef enum logic [2:0] {
		MODE_OFF = 3'b000,
		MODE_TIMER = 3'b001,
		MODE_EDGE = 3'b010,
		MODE_CHANGE = 3'b011,
		MODE_INPUT = 3'b100
	} mode_t;
	// timing: timer counts hundredths of a second
	localparam int CLK_HZ = 10_000_000;
	localparam int TICK_MS = 10;
	localparam int PULSE_MS = 5;
	localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
	localparam int PULSE_CYCLES = CLK_HZ / 1000 * PULSE_MS;
	// register offsets (byte addresses)
	localparam logic [3:0] REG_ADDR = 4'h0;
	localparam logic [3:0] REG_MODE = 4'h4;
	localparam logic [3:0] REG_IO = 4'h8;
	localparam logic [3:0] REG_TIMER = 4'hC;
	// reset values
	localparam logic [7:0] RST_ADDR = 8'h31;
	localparam logic [7:0] RST_PEER = 8'h31;
	localparam logic [27:0] RST_TIMER = 28'h0000000;
	// carriers
	typedef struct packed {
		logic valid;
		logic [7:0] data;
	} rx_t;
	typedef struct packed {
		logic wr;
		logic rd;
		logic [3:0] addr;
		logic [31:0] wdata;
	} bus_req_t;
endpackage : cio_pkg

//--- hdl/continuous_io_mode_ctrl.sv
// continuous i/o mode controller: command parser, status sender, triggers
// assumes a byte uart outside: tx_ready takes a byte, tx_idle means shifter empty
`timescale 1ns/1ps
// What this block does
// - input mode: peer status string drives outputs
// - accept disable, timer, edge, change, input commands
// - mode read answers D, T, E, C, I
// - set and read back continuous timer
// - low trigger pulse after each status string
// - default pin input except during pulse
// - timer expiry sends long-form status string
// - disable command needs no write enable
// - dollar or hash suspends continuous output
// - matching address: execute rest of command
// - foreign address: resume continuous output
// - output commands accepted in timer mode
// - status reports outputs as well as inputs
// - disable gives polled module, timer enable restarts
// - edge mode: line zero is trigger input
// - edge mode reacts to rising edge only
// - edge mode waits timer value before sending
// - trigger edge acts like long-form input read
// - direction mask ones make lines outputs
// - string: prompt, address, hex status, checksum, CR
// - timer period restarts after each timeout
// - change mode sends when lines differ
module continuous_io_mode_ctrl #(
	parameter int LINES = 15,
	parameter int TICK_CYCLES = cio_pkg::TICK_CYCLES,
	parameter int PULSE_CYCLES = cio_pkg::PULSE_CYCLES
) (
	input wire logic clk,
	input wire logic reset,
	input wire cio_pkg::rx_t rx,
	input wire logic tx_ready,
	input wire logic tx_idle,
	output logic tx_valid,
	output logic [7:0] tx_data,
	input wire logic [LINES-1:0] io_in,
	output logic [LINES-1:0] io_out,
	output logic [LINES-1:0] io_dir,
	output logic default_out,
	output logic default_oe,
	input wire cio_pkg::bus_req_t bus,
	output logic [31:0] rd_data
);
	typedef enum logic [2:0] {
		S_IDLE = 3'b000,
		S_ADDR = 3'b001,
		S_BODY = 3'b010,
		S_EXEC = 3'b011,
		S_SEND = 3'b100
	} state_t;

	state_t state;
	cio_pkg::mode_t mode;
	logic [7:0] own_addr, peer_addr, mode_char;
	logic [7:0] body [12];
	logic [3:0] bi;
	logic long_form, peer, we, arm_req, is_status, status_done, pend;
	logic [7:0] txmsg [20];
	logic [4:0] ti, tn;
	logic [27:0] timer_bcd, cd;
	logic [15:0] io_state, last_sent, hexarg;
	logic [LINES-1:0] dir_cfg;
	logic [16:0] tick_cnt;
	logic [16:0] pcnt;
	logic io0_prev, wait_idle, status_go, armed_edge;
	logic is_cm, is_rcm, is_ct, is_rct, is_cia, is_we, is_di, is_do;
	logic is_sb, is_cb, is_aio, prot, bad;
	logic [7:0] msg [20];
	logic [4:0] n, cmdlen;
	logic [7:0] sum;

	function automatic logic [7:0] hexc(input logic [3:0] v);
		return (v < 4'hA) ? cio_pkg::CH_ZERO + {4'h0, v} : cio_pkg::CH_HEX_OFS + {4'h0, v};
	endfunction : hexc

	function automatic logic [3:0] hexv(input logic [7:0] c);
		return c[6] ? c[3:0] + 4'h9 : c[3:0];
	endfunction : hexv

	// decrement of seven bcd digits, borrow ripples upward
	function automatic logic [27:0] bcd_dec(input logic [27:0] v);
		logic borrow;
		logic [27:0] r;
		borrow = 1'b1;
		r = v;
		for (int k = 0; k < 7; k++)
		begin
			if (borrow)
			begin
				if (v[4*k +: 4] == 4'h0)
					r[4*k +: 4] = 4'h9;
				else
				begin
					r[4*k +: 4] = v[4*k +: 4] - 4'h1;
					borrow = 1'b0;
				end
			end
		end
		return r;
	endfunction : bcd_dec

	// status word: outputs read back from their latches, absent lines read 1
	genvar g;
	generate
		for (g = 0; g < 16; g++)
		begin : g_state
			if (g < LINES)
			begin : g_line
				assign io_state[g] = io_dir[g] ? io_out[g] : io_in[g];
			end
			else
			begin : g_pad
				assign io_state[g] = 1'b1;
			end
		end
	endgenerate

	always_comb
	begin
		unique case (mode)
			cio_pkg::MODE_TIMER: mode_char = "T";
			cio_pkg::MODE_EDGE: mode_char = "E";
			cio_pkg::MODE_CHANGE: mode_char = "C";
			cio_pkg::MODE_INPUT: mode_char = "I";
			default: mode_char = "D";
		endcase
	end

	// command decode from the collected body
	always_comb
	begin
		is_cm = body[0] == "C" && body[1] == "M" && bi == 4'd3 &&
			(body[2] == "D" || body[2] == "T" || body[2] == "E" ||
			body[2] == "C" || body[2] == "I");
		// lengths checked too: body bytes of an older, longer command linger
		is_rcm = body[0] == "R" && body[1] == "C" && body[2] == "M" && bi == 4'd3;
		is_ct = body[0] == "C" && body[1] == "T" && bi == 4'd11;
		is_rct = body[0] == "R" && body[1] == "C" && body[2] == "T" && bi == 4'd3;
		is_cia = body[0] == "C" && body[1] == "I" && body[2] == "A" && bi == 4'd4;
		is_we = body[0] == "W" && body[1] == "E" && bi == 4'd2;
		is_di = body[0] == "D" && body[1] == "I" && bi == 4'd2;
		is_do = body[0] == "D" && body[1] == "O" && bi == 4'd6;
		is_sb = body[0] == "S" && body[1] == "B" && bi == 4'd4;
		is_cb = body[0] == "C" && body[1] == "B" && bi == 4'd4;
		is_aio = body[0] == "A" && body[1] == "I" && body[2] == "O" && bi == 4'd7;
		// disable is exempt from write protection
		prot = (is_cm && body[2] != "D") || is_ct || is_cia || is_aio;
		bad = !(is_cm || is_rcm || is_ct || is_rct || is_cia || is_we ||
			is_di || is_do || is_sb || is_cb || is_aio) || (prot && !we);
		cmdlen = (is_rcm || is_rct || is_cia || is_aio || is_cm) ? 5'd3 : 5'd2;
		hexarg = is_aio ? {hexv(body[3]), hexv(body[4]), hexv(body[5]), hexv(body[6])}
			: {hexv(body[2]), hexv(body[3]), hexv(body[4]), hexv(body[5])};
	end

	// answer builder; a status string is a long-form input read answer
	assign status_go = state == S_IDLE && pend && !(rx.valid &&
		(rx.data == cio_pkg::CH_DOLLAR || rx.data == cio_pkg::CH_HASH ||
		(rx.data == cio_pkg::CH_STAR && mode == cio_pkg::MODE_INPUT)));
	always_comb
	begin
		for (int k = 0; k < 20; k++)
			msg[k] = 8'h00;
		n = 5'd0;
		sum = 8'h00;
		if (!status_go && bad)
		begin
			msg[0] = cio_pkg::CH_QUERY;
			n = 5'd1;
		end
		else
		begin
			msg[0] = cio_pkg::CH_STAR;
			n = 5'd1;
			if (status_go || long_form)
			begin
				msg[1] = own_addr;
				n = 5'd2;
				if (status_go)
				begin
					msg[2] = "D";
					msg[3] = "I";
					n = 5'd4;
				end
				else
				begin
					for (int k = 0; k < 3; k++)
						if (5'(k) < cmdlen)
							msg[2+k] = body[k];
					n = 5'd2 + cmdlen;
				end
			end
			if (status_go || is_di)
			begin
				for (int k = 0; k < 4; k++)
					msg[n+5'(k)] = hexc(io_state[15-4*k -: 4]);
				n = n + 5'd4;
			end
			else if (is_rcm)
			begin
				msg[n] = mode_char;
				n = n + 5'd1;
			end
			else if (is_rct)
			begin
				msg[n] = cio_pkg::CH_PLUS;
				for (int k = 0; k < 5; k++)
					msg[n+5'd1+5'(k)] = cio_pkg::CH_ZERO + {4'h0, timer_bcd[27-4*k -: 4]};
				msg[n+5'd6] = cio_pkg::CH_DOT;
				msg[n+5'd7] = cio_pkg::CH_ZERO + {4'h0, timer_bcd[7:4]};
				msg[n+5'd8] = cio_pkg::CH_ZERO + {4'h0, timer_bcd[3:0]};
				n = n + 5'd9;
			end
			if (status_go || long_form)
			begin
				for (int k = 0; k < 18; k++)
					if (5'(k) < n)
						sum = sum + msg[k];
				msg[n] = hexc(sum[7:4]);
				msg[n+5'd1] = hexc(sum[3:0]);
				n = n + 5'd2;
			end
		end
		msg[n] = cio_pkg::CH_CR;
		n = n + 5'd1;
	end

	// command parser and sender
	always_ff @(posedge clk)
	begin
		arm_req <= 1'b0;
		status_done <= 1'b0;
		if (reset)
		begin
			state <= S_IDLE;
			mode <= cio_pkg::MODE_OFF;
			bi <= 4'd0;
			long_form <= 1'b0;
			peer <= 1'b0;
			we <= 1'b0;
			is_status <= 1'b0;
			ti <= 5'd0;
			tn <= 5'd0;
			tx_valid <= 1'b0;
			tx_data <= 8'h00;
			timer_bcd <= cio_pkg::RST_TIMER;
			peer_addr <= cio_pkg::RST_PEER;
			io_out <= '0;
			dir_cfg <= '0;
			last_sent <= 16'h0000;
			for (int k = 0; k < 12; k++)
				body[k] <= 8'h00;
			for (int k = 0; k < 20; k++)
				txmsg[k] <= 8'h00;
		end
		else
		begin
			unique case (state)
				S_IDLE:
				begin
					// a command start suspends any pending status string
					if (rx.valid && (rx.data == cio_pkg::CH_DOLLAR ||
						rx.data == cio_pkg::CH_HASH))
					begin
						state <= S_ADDR;
						long_form <= rx.data == cio_pkg::CH_HASH;
						peer <= 1'b0;
					end
					else if (rx.valid && rx.data == cio_pkg::CH_STAR &&
						mode == cio_pkg::MODE_INPUT)
					begin
						state <= S_ADDR;
						long_form <= 1'b0;
						peer <= 1'b1;
					end
					else if (status_go)
					begin
						txmsg <= msg;
						tn <= n;
						ti <= 5'd0;
						tx_valid <= 1'b1;
						tx_data <= msg[0];
						is_status <= 1'b1;
						last_sent <= io_state;
						state <= S_SEND;
					end
				end
				S_ADDR:
					if (rx.valid)
					begin
						bi <= 4'd0;
						if (rx.data == (peer ? peer_addr : own_addr))
							state <= S_BODY;
						else
							state <= S_IDLE;
					end
				S_BODY:
					if (rx.valid)
					begin
						if (rx.data == cio_pkg::CH_CR)
							state <= S_EXEC;
						else if (bi != 4'd12)
						begin
							body[bi] <= rx.data;
							bi <= bi + 4'd1;
						end
					end
				S_EXEC:
				begin
					if (peer)
					begin
						// peer string is DI plus hex data and checksum
						if (body[0] == "D" && body[1] == "I")
							io_out <= hexarg[LINES-1:0];
						state <= S_IDLE;
					end
					else
					begin
						if (!bad)
						begin
							we <= is_we;
							if (is_cm)
							begin
								unique case (body[2])
									"T": mode <= cio_pkg::MODE_TIMER;
									"E": mode <= cio_pkg::MODE_EDGE;
									"C": mode <= cio_pkg::MODE_CHANGE;
									"I": mode <= cio_pkg::MODE_INPUT;
									default: mode <= cio_pkg::MODE_OFF;
								endcase
								arm_req <= 1'b1;
							end
							if (is_ct)
								timer_bcd <= {body[3][3:0], body[4][3:0], body[5][3:0],
									body[6][3:0], body[7][3:0], body[9][3:0],
									body[10][3:0]};
							if (is_cia)
								peer_addr <= body[3];
							if (is_aio)
								dir_cfg <= hexarg[LINES-1:0];
							// output commands work in any mode
							if (is_do)
								io_out <= hexarg[LINES-1:0];
							if (is_sb || is_cb)
								for (int k = 0; k < LINES; k++)
									if ({hexv(body[2]), hexv(body[3])} == 8'(k))
										io_out[k] <= is_sb;
						end
						txmsg <= msg;
						tn <= n;
						ti <= 5'd0;
						tx_valid <= 1'b1;
						tx_data <= msg[0];
						is_status <= 1'b0;
						state <= S_SEND;
					end
				end
				S_SEND:
					if (tx_ready)
					begin
						if (ti + 5'd1 == tn)
						begin
							tx_valid <= 1'b0;
							status_done <= is_status;
							state <= S_IDLE;
						end
						else
						begin
							tx_data <= txmsg[ti+5'd1];
							ti <= ti + 5'd1;
						end
					end
				default:
					state <= S_IDLE;
			endcase
		end
	end

	// line zero is held as the trigger input in edge mode
	always_ff @(posedge clk)
	begin
		if (reset)
			io_dir <= '0;
		else
		begin
			io_dir <= dir_cfg;
			if (mode == cio_pkg::MODE_EDGE)
				io_dir[0] <= 1'b0;
		end
	end

	// trigger sources: period timer, edge delay, change detect
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			tick_cnt <= 17'd0;
			cd <= 28'h0000000;
			pend <= 1'b0;
			io0_prev <= 1'b0;
		end
		else
		begin
			io0_prev <= io_in[0];
			tick_cnt <= (tick_cnt == 17'(TICK_CYCLES - 1)) ? 17'd0 : tick_cnt + 17'd1;
			if (status_go)
				pend <= 1'b0;
			unique case (mode)
				cio_pkg::MODE_TIMER:
					if (arm_req)
						cd <= timer_bcd;
					else if (cd == 28'h0000000)
					begin
						pend <= 1'b1;
						cd <= timer_bcd;
					end
					else if (tick_cnt == 17'(TICK_CYCLES - 1))
						cd <= bcd_dec(cd);
				cio_pkg::MODE_EDGE:
					// a stuck-high trigger fires once; only the low-to-high step counts
					if (io_in[0] && !io0_prev)
						cd <= timer_bcd;
					// no re-arm while pend stands, or one edge would send twice
					else if (cd == 28'h0000000 && io0_prev == io_in[0] && armed_edge && !pend)
						pend <= 1'b1;
					else if (tick_cnt == 17'(TICK_CYCLES - 1) && cd != 28'h0000000)
						cd <= bcd_dec(cd);
				cio_pkg::MODE_CHANGE:
					if (state == S_IDLE && !status_go && io_state != last_sent)
						pend <= 1'b1;
				default:
					pend <= 1'b0;
			endcase
		end
	end

	// edge trigger waits for its delay; cleared once the string is queued
	always_ff @(posedge clk)
	begin
		if (reset)
			armed_edge <= 1'b0;
		else if (mode == cio_pkg::MODE_EDGE && io_in[0] && !io0_prev)
			armed_edge <= 1'b1;
		else if (mode != cio_pkg::MODE_EDGE || pend)
			armed_edge <= 1'b0;
	end

	// daisy-chain pulse waits for the uart shifter to drain
	always_ff @(posedge clk)
	begin
		default_out <= 1'b0;
		if (reset)
		begin
			wait_idle <= 1'b0;
			default_oe <= 1'b0;
			pcnt <= 17'd0;
		end
		else if (status_done)
			wait_idle <= 1'b1;
		else if (wait_idle && tx_idle)
		begin
			wait_idle <= 1'b0;
			default_oe <= 1'b1;
			pcnt <= 17'(PULSE_CYCLES - 1);
		end
		else if (default_oe)
		begin
			if (pcnt == 17'd0)
				default_oe <= 1'b0;
			else
				pcnt <= pcnt - 17'd1;
		end
	end

	// register port: address steers parsing, others show state
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			own_addr <= cio_pkg::RST_ADDR;
			rd_data <= 32'h00000000;
		end
		else
		begin
			if (bus.wr && bus.addr == cio_pkg::REG_ADDR)
				own_addr <= bus.wdata[7:0];
			rd_data <= 32'h00000000;
			if (bus.rd)
				unique case (bus.addr)
					cio_pkg::REG_ADDR: rd_data <= {24'h000000, own_addr};
					cio_pkg::REG_MODE: rd_data <= {24'h000000, mode_char};
					cio_pkg::REG_IO: rd_data <= {16'h0000, io_state};
					cio_pkg::REG_TIMER: rd_data <= {4'h0, timer_bcd};
					default: rd_data <= 32'h00000000;
				endcase
		end
	end

	// checks
	default clocking cb_main @(posedge clk); endclocking
	default disable iff (reset);
	logic [16:0] oe_len;
	always_ff @(posedge clk)
		oe_len <= default_oe ? oe_len + 17'd1 : 17'd0;

	a_pulse_width: assert property ($fell(default_oe) |-> oe_len == 17'(PULSE_CYCLES))
		else $error("trigger pulse width wrong");
	a_pulse_start: assert property ($rose(default_oe) |-> $past(tx_idle) && !tx_valid)
		else $error("pulse before string drained");
	a_pin_low: assert property (default_oe |-> !default_out)
		else $error("default pin not low");
	a_cmd_free: assert property (state == S_EXEC && !peer && is_cm && body[2] == "D"
		|=> mode == cio_pkg::MODE_OFF)
		else $error("disable refused");
	a_start_suspend: assert property (state == S_IDLE && rx.valid &&
		rx.data == cio_pkg::CH_DOLLAR |=> state == S_ADDR && !tx_valid)
		else $error("start not taken");
	a_addr_miss: assert property (state == S_ADDR && rx.valid && !peer &&
		rx.data != own_addr |=> state == S_IDLE)
		else $error("foreign address kept");
	a_edge_dir: assert property (mode == cio_pkg::MODE_EDGE [*2] |-> !io_dir[0])
		else $error("trigger line not input");
	a_status_form: assert property (status_go |=> txmsg[0] == cio_pkg::CH_STAR &&
		txmsg[1] == own_addr && txmsg[2] == "D" && tx_valid)
		else $error("status string malformed");
	a_peer_drive: assert property (state == S_EXEC && peer && body[0] == "D" &&
		body[1] == "I" |=> io_out == $past(hexarg[LINES-1:0]))
		else $error("peer data not driven");

	c_timer_send: cover property (mode == cio_pkg::MODE_TIMER && status_go);
	c_edge_send: cover property (mode == cio_pkg::MODE_EDGE && status_go);
	c_peer_input: cover property (state == S_EXEC && peer);
	c_pulse: cover property ($fell(default_oe));
endmodule : continuous_io_mode_ctrl

//--- test/cio_link_model.sv
// link model: the host or peer uart on the far side of the byte link
// assumes one byte shifter and no fifo, so every byte stalls the sender
`timescale 1ns/1ps
module cio_link_model #(
	parameter int SHIFT = 4
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic tx_valid,
	input wire logic [7:0] tx_data,
	output logic tx_ready,
	output logic tx_idle,
	output cio_pkg::rx_t rx
);
	logic [7:0] got[$];
	int busy;
	int cyc;
	int last_cr;
	// shifter busy blocks the next byte and holds idle low
	assign tx_ready = (busy == 0);
	assign tx_idle = (busy == 0); // low until the last bit leaves
	// capture sent bytes and note the cycle of each carriage return
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		if (reset)
			busy <= 0;
		else if (tx_valid && tx_ready)
		begin
			got.push_back(tx_data);
			busy <= SHIFT;
			if (tx_data == cio_pkg::CH_CR)
				last_cr <= cyc;
		end
		else if (busy > 0)
			busy <= busy - 1;
	end
	// framed bytes with a gap; idle line shows the inverted last byte
	task automatic send(input string s);
		for (int i = 0; i < s.len(); i++)
		begin
			@(posedge clk);
			rx <= '{1'b1, s[i]};
			@(posedge clk);
			rx <= '{1'b0, ~s[i]};
		end
	endtask : send
	initial rx = '0;
endmodule : cio_link_model

//--- test/continuous_io_mode_ctrl_tb_top.sv
// testbench: commands over the byte link, register reads, status strings
// assumes the link model beside it and short tick and pulse counts
`timescale 1ns/1ps
module continuous_io_mode_ctrl_tb_top;
	localparam int TICK = 10;
	localparam int PULSE = 5;
	localparam logic [7:0] CR = 8'h0D;
	logic clk;
	logic reset;
	cio_pkg::rx_t rx;
	logic tx_ready, tx_idle, tx_valid, default_out, default_oe;
	logic [7:0] tx_data;
	logic [14:0] io_in, io_out, io_dir, out_m, dir_m;
	cio_pkg::bus_req_t bus;
	logic [31:0] rd_data;
	int failures, n_compared, cycles, t1;
	string s;
	string kinds = "TEI";
	continuous_io_mode_ctrl #(.LINES(15), .TICK_CYCLES(TICK), .PULSE_CYCLES(PULSE))
		continuous_io_mode_ctrl_i (.clk(clk), .reset(reset), .rx(rx), .tx_ready(tx_ready),
		.tx_idle(tx_idle), .tx_valid(tx_valid), .tx_data(tx_data), .io_in(io_in),
		.io_out(io_out), .io_dir(io_dir), .default_out(default_out),
		.default_oe(default_oe), .bus(bus), .rd_data(rd_data));
	cio_link_model #(.SHIFT(4)) cio_link_model_i (.clk(clk), .reset(reset),
		.tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready), .tx_idle(tx_idle),
		.rx(rx));
	// clock and hang guard
	initial
	begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 30000)
		begin
			failures++;
			give_verdict();
		end
	end
	task automatic give_verdict();
		if (failures == 0 && n_compared > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : give_verdict
	task automatic chk_v(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_compared++;
		if (got !== exp)
		begin
			failures++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask : chk_v
	task automatic chk_s(input string what, input string exp, input string got);
		n_compared++;
		if (got != exp)
		begin
			failures++;
			$display("BAD %s expected %s seen %s", what, exp, got);
		end
	endtask : chk_s
	// string helpers: upper-case hex, trailing return, checksum framing
	function automatic logic [7:0] hx(input logic [3:0] n);
		return (n < 4'hA) ? 8'h30 + {4'h0, n} : 8'h37 + {4'h0, n};
	endfunction : hx
	function automatic string cr(input string x);
		return $sformatf("%s%c", x, CR);
	endfunction : cr
	function automatic string framed(input string x);
		logic [7:0] sum;
		sum = 8'h00;
		for (int i = 0; i < x.len(); i++)
			sum += x[i];
		return cr($sformatf("%s%c%c", x, hx(sum[7:4]), hx(sum[3:0])));
	endfunction : framed
	// absent line 15 reads one, outputs read their latch
	function automatic string status();
		logic [15:0] v;
		v = {1'b1, (dir_m & out_m) | (~dir_m & io_in)};
		return framed($sformatf("*1DI%c%c%c%c", hx(v[15:12]), hx(v[11:8]), hx(v[7:4]),
			hx(v[3:0])));
	endfunction : status
	// register port: one-cycle strobes, read data only in the next cycle
	task automatic bus_wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk);
		bus <= '{1'b1, 1'b0, a, d};
		@(posedge clk);
		bus <= '0;
	endtask : bus_wr
	task automatic bus_rd(input logic [3:0] a, input logic [31:0] exp, input string what);
		@(posedge clk);
		bus <= '{1'b0, 1'b1, a, 32'h00000000};
		@(posedge clk);
		bus <= '0;
		#1 chk_v(what, exp, rd_data);
	endtask : bus_rd
	// gather sent bytes up to a return, with a bounded wait
	task automatic take(output string x);
		x = "";
		for (int i = 0; i < 2000; i++)
		begin
			@(posedge clk);
			if (cio_link_model_i.got.size() > 0 && cio_link_model_i.got[$] == CR)
				break;
		end
		// let the model's nonblocking notes (last_cr) settle first
		#1;
		while (cio_link_model_i.got.size() > 0)
			x = $sformatf("%s%c", x, cio_link_model_i.got.pop_front());
	endtask : take
	task automatic cmd(input string c, input string exp);
		string x;
		cio_link_model_i.send(cr(c));
		take(x);
		chk_s(c, exp, x);
	endtask : cmd
	task automatic quiet(input int n);
		repeat (n) @(posedge clk);
		chk_v("silence", 32'h00000000, cio_link_model_i.got.size());
	endtask : quiet
	// pulse must wait for the shifter to empty, then last exactly PULSE cycles
	task automatic pulse_check();
		int w;
		w = 0;
		while (default_oe !== 1'b1 && w < 200)
		begin
			@(posedge clk);
			#1 w++;
		end
		chk_v("pulse start", 1, cio_link_model_i.cyc - cio_link_model_i.last_cr >= 6);
		w = 0;
		while (default_oe === 1'b1 && w < 200)
		begin
			chk_v("pulse level", 0, default_out);
			@(posedge clk);
			#1 w++;
		end
		chk_v("pulse length", PULSE, w);
	endtask : pulse_check
	// main sequence
	initial
	begin
		reset = 1'b1;
		bus = '0;
		io_in = 15'h0054;
		out_m = 15'h0000;
		dir_m = 15'h0000;
		repeat (8) @(posedge clk);
		reset <= 1'b0;
		bus_rd(cio_pkg::REG_ADDR, 32'h00000031, "own address");
		bus_rd(cio_pkg::REG_MODE, 32'h00000044, "mode letter");
		bus_wr(cio_pkg::REG_MODE, 32'h00000054);
		bus_rd(cio_pkg::REG_MODE, 32'h00000044, "read-only mode");
		bus_rd(4'h2, 32'h00000000, "unmapped");
		chk_v("pin idle", 0, default_oe);
		cio_link_model_i.send(cr("$2WE"));
		quiet(200);
		cmd("$1CMT", cr("?"));
		cmd("$1CMD", cr("*"));
		cmd("$1WE", cr("*"));
		cmd("$1CT+00010.00", cr("*"));
		cmd("$1RCT", cr("*+00010.00"));
		bus_rd(cio_pkg::REG_TIMER, 32'h00001000, "timer digits");
		// timer, edge and input modes, each written under write enable, read back by letter
		for (int i = 0; i < 3; i++)
		begin
			cmd("$1WE", cr("*"));
			cmd({"$1CM", kinds.substr(i, i)}, cr("*"));
			cmd("$1RCM", cr({"*", kinds.substr(i, i)}));
		end
		cmd("$1WE", cr("*"));
		cmd("$1CMC", cr("*"));
		repeat (300) @(posedge clk);
		cio_link_model_i.got.delete();
		bus_rd(cio_pkg::REG_MODE, 32'h00000043, "change letter");
		io_in <= 15'h0050;
		take(s);
		chk_s("change string", status(), s);
		cmd("#1CMD", framed("*1CMD"));
		cmd("$1RCM", cr("*D"));
		// timer mode with outputs on the upper lines
		cmd("$1WE", cr("*"));
		cmd("$1AIOFF00", cr("*"));
		dir_m = 15'h7F00;
		chk_v("direction", 15'h7F00, io_dir);
		cmd("$1DO1234", cr("*"));
		out_m = 15'h1234;
		cmd("$1WE", cr("*"));
		cmd("$1CT+00000.20", cr("*"));
		cmd("$1WE", cr("*"));
		cmd("$1CMT", cr("*"));
		take(s);
		chk_s("timer string", status(), s);
		t1 = cio_link_model_i.last_cr;
		pulse_check();
		take(s);
		chk_s("timer again", status(), s);
		chk_v("period", 20 * TICK, cio_link_model_i.last_cr - t1);
		cmd("$1SB0A", cr("*"));
		out_m[10] = 1'b1;
		chk_v("bit set", 1, io_out[10]);
		take(s);
		chk_s("timer with bit", status(), s);
		cmd("#1CMD", framed("*1CMD"));
		quiet(400);
		cmd("#1DI", status());
		cmd("$1CB0A", cr("*"));
		out_m[10] = 1'b0;
		chk_v("bit clear", 0, io_out[10]);
		cmd("$1WE", cr("*"));
		cmd("$1CMT", cr("*"));
		take(s);
		chk_s("restart", status(), s);
		cmd("#1CMD", framed("*1CMD"));
		// edge trigger on line zero, rising only, no delay
		cmd("$1WE", cr("*"));
		cmd("$1CT+00000.00", cr("*"));
		cmd("$1WE", cr("*"));
		cmd("$1CME", cr("*"));
		chk_v("trigger input", 0, io_dir[0]);
		@(posedge clk);
		io_in <= 15'h0055;
		take(s);
		chk_s("edge string", status(), s);
		pulse_check();
		@(posedge clk);
		io_in <= 15'h0054;
		quiet(300);
		// peer string drives the output lines, only from the peer address
		cmd("$1WE", cr("*"));
		cmd("$1CIA2", cr("*"));
		cmd("$1WE", cr("*"));
		cmd("$1CMI", cr("*"));
		cio_link_model_i.send(framed("*1DI7F00"));
		quiet(100);
		chk_v("foreign peer", 15'h1200, io_out & io_dir);
		cio_link_model_i.send(framed("*2DI0A5F"));
		quiet(100);
		chk_v("peer outputs", 15'h0A00, io_out & io_dir);
		give_verdict();
	end
endmodule : continuous_io_mode_ctrl_tb_top
